// ### hdl/fsr_fault_status.sv
// fsr_fault_status: four byte-wide fault status registers reached by command
// code, with alert masking and summary bits. assumes the command front end and
// event sources run on clk_i; threshold comparators arrive asynchronously.
//
// Overview of operation
// - output current register latches overcurrent fault bit 7, warning bit 5.
// - output current bits 6 and 4:0 always read zero.
// - clear-faults or writing one clears a latched bit; others stay.
// - input register latches overvoltage fault bit 7; bit 6 reads zero.
// - input register latches undervoltage warning bit 5; bits 4, 2:0 zero.
// - input bit 3 is live: one while power input counts as off.
// - low-input flag set when input or aux supply blocks conversion; never alerts.
// - low-input flag reads one straight after reset without alerting.
// - undervoltage warning suppressed until input first exceeds turn-on threshold.
// - temperature register latches fault bit 7, warning bit 6; rest zero.
// - communication register latches bit 7 on an invalid command.
// - communication register latches bit 6 on invalid data.
// - communication register latches bit 5 on packet error check failure.
// - communication register latches bit 4 memory error, bit 3 core error.
// - communication register latches bit 1 link error; bits 2 and 0 zero.
// - each alerting bit has a mask bit; set mask blocks its alert.
// - stacked secondary reports back-channel trouble as a communication fault.
// - communication summary bit is OR of communication register bits.
// - byte read and byte write by command code; contents update live.
// - status word bit 14 for current faults, bit 13 for input faults.
`timescale 1ns/100ps
`default_nettype none
module fsr_fault_status
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // command port from the management front end
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic [7:0] cmd_wdata_i,
  input  wire logic       clear_faults_i,
  output logic            rvalid_o,
  output logic [7:0]      rdata_o,
  // fault events, one-cycle pulses on clk_i
  input  wire logic       oc_fault_evt_i,
  input  wire logic       oc_warn_evt_i,
  input  wire logic       vin_ov_fault_evt_i,
  input  wire logic       vin_uv_warn_evt_i,
  input  wire logic       ot_fault_evt_i,
  input  wire logic       ot_warn_evt_i,
  input  wire logic       bad_command_evt_i,
  input  wire logic       bad_payload_evt_i,
  input  wire logic       pec_fail_evt_i,
  input  wire logic       memory_error_evt_i,
  input  wire logic       core_error_evt_i,
  input  wire logic       link_error_evt_i,
  input  wire logic       back_channel_error_evt_i,
  // asynchronous comparator levels
  input  wire logic       power_input_rail_above_on_i,
  input  wire logic       power_input_rail_below_off_i,
  input  wire logic       aux_uvlo_i,
  // alert masks, one bit per register position
  input  wire logic [7:0] alert_mask_iout_i,
  input  wire logic [7:0] alert_mask_input_i,
  input  wire logic [7:0] alert_mask_temp_i,
  input  wire logic [7:0] alert_mask_cml_i,
  // summaries and alert
  output logic            alert_o,
  output logic            status_word_iout_o,
  output logic            status_word_input_o,
  output logic            status_byte_cml_o,
  output logic            input_too_low_live_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  function automatic logic [7:0] wr1c(input logic [7:0] code);
    return (cmd_valid_i && cmd_write_i && cmd_code_i == code) ? cmd_wdata_i : 8'h00;
  endfunction

  function automatic logic [7:0] bit8(input logic v, input int pos);
    return v ? (8'h01 << pos[2:0]) : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchronisers

  logic above_on;
  logic below_off;
  logic aux_low;

  fsr_pin_sync u_sync_on (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (power_input_rail_above_on_i),
    .level_o  (above_on)
  );

  fsr_pin_sync u_sync_off (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (power_input_rail_below_off_i),
    .level_o  (below_off)
  );

  fsr_pin_sync u_sync_aux (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (aux_uvlo_i),
    .level_o  (aux_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  // live low-input flag and undervoltage arming

  logic input_too_low_live_flag;
  logic uvw_armed;

  // hysteresis between turn-off and turn-on thresholds
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_too_low_live_flag <= FSR_RST_INPUT_TOO_LOW_LIVE_FLAG;
    end else if (aux_low || below_off) begin
      input_too_low_live_flag <= 1'b1;
    end else if (above_on) begin
      input_too_low_live_flag <= 1'b0;
    end
  end

  // warning stays quiet during the first ramp-up after reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uvw_armed <= 1'b0;
    end else if (above_on) begin
      uvw_armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched registers

  logic [7:0] iout_flags;
  logic [7:0] input_flags;
  logic [7:0] temp_flags;
  logic [7:0] cml_flags;

  fsr_sticky_byte #(.SUPPORTED(FSR_SUP_IOUT)) u_iout (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .set_i     (bit8(oc_fault_evt_i, FSR_BIT_OC_FAULT)
              | bit8(oc_warn_evt_i, FSR_BIT_OC_WARN)),
    .wr1c_i    (wr1c(FSR_CODE_IOUT)),
    .clr_all_i (clear_faults_i),
    .flags_o   (iout_flags)
  );

  fsr_sticky_byte #(.SUPPORTED(FSR_SUP_INPUT)) u_input (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .set_i     (bit8(vin_ov_fault_evt_i, FSR_BIT_IN_OV_FLT)
              | bit8(vin_uv_warn_evt_i && uvw_armed, FSR_BIT_IN_UV_WARN)),
    .wr1c_i    (wr1c(FSR_CODE_INPUT)),
    .clr_all_i (clear_faults_i),
    .flags_o   (input_flags)
  );

  fsr_sticky_byte #(.SUPPORTED(FSR_SUP_TEMP)) u_temp (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .set_i     (bit8(ot_fault_evt_i, FSR_BIT_OT_FAULT)
              | bit8(ot_warn_evt_i, FSR_BIT_OT_WARN)),
    .wr1c_i    (wr1c(FSR_CODE_TEMP)),
    .clr_all_i (clear_faults_i),
    .flags_o   (temp_flags)
  );

  fsr_sticky_byte #(.SUPPORTED(FSR_SUP_CML)) u_cml (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .set_i     (bit8(bad_command_evt_i, FSR_BIT_BAD_CMD)
              | bit8(bad_payload_evt_i, FSR_BIT_BAD_DATA)
              | bit8(pec_fail_evt_i, FSR_BIT_PEC)
              | bit8(memory_error_evt_i, FSR_BIT_MEM)
              | bit8(core_error_evt_i, FSR_BIT_CORE)
              | bit8(link_error_evt_i || back_channel_error_evt_i, FSR_BIT_LINK)),
    .wr1c_i    (wr1c(FSR_CODE_CML)),
    .clr_all_i (clear_faults_i),
    .flags_o   (cml_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // readback

  logic [7:0] input_view;

  assign input_view = input_flags | bit8(input_too_low_live_flag, FSR_BIT_IN_TOO_LOW);

  // answer one cycle after the request; unknown codes read zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= FSR_RDATA_NONE;
    end else begin
      rvalid_o <= cmd_valid_i && !cmd_write_i;
      if (cmd_valid_i && !cmd_write_i) begin
        case (cmd_code_i)
          FSR_CODE_IOUT:  rdata_o <= iout_flags;
          FSR_CODE_INPUT: rdata_o <= input_view;
          FSR_CODE_TEMP:  rdata_o <= temp_flags;
          FSR_CODE_CML:   rdata_o <= cml_flags;
          default:        rdata_o <= FSR_RDATA_NONE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summaries and alert

  logic next_alert;

  // live low-input bit is left out of the alert on purpose
  assign next_alert = |(iout_flags & ~alert_mask_iout_i)
                    | |(input_flags & ~alert_mask_input_i)
                    | |(temp_flags & ~alert_mask_temp_i)
                    | |(cml_flags & ~alert_mask_cml_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alert_o                   <= 1'b0;
      status_word_iout_o        <= 1'b0;
      status_word_input_o       <= 1'b0;
      status_byte_cml_o         <= 1'b0;
      input_too_low_live_flag_o <= FSR_RST_INPUT_TOO_LOW_LIVE_FLAG;
    end else begin
      alert_o                   <= next_alert;
      status_word_iout_o        <= |iout_flags;
      status_word_input_o       <= |input_flags;
      status_byte_cml_o         <= |cml_flags;
      input_too_low_live_flag_o <= input_too_low_live_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_OC_FAULT_LATCH: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    oc_fault_evt_i |=> iout_flags[FSR_BIT_OC_FAULT])
    else $error("overcurrent fault not latched");

  AST_IOUT_ZERO_BITS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (iout_flags & ~FSR_SUP_IOUT) == 8'h00)
    else $error("unsupported current bit set");

  AST_CLEAR_ALL: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    clear_faults_i && !oc_fault_evt_i && !oc_warn_evt_i |=> iout_flags == 8'h00)
    else $error("clear-faults left warning set");

  AST_ZERO_WRITE_KEEPS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_valid_i && cmd_write_i && cmd_wdata_i == 8'h00 && !clear_faults_i
      |=> $past(temp_flags) == (temp_flags & $past(temp_flags)))
    else $error("zero write cleared a flag");

  AST_UVW_SUPPRESSED: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !uvw_armed && !input_flags[FSR_BIT_IN_UV_WARN] |=> !input_flags[FSR_BIT_IN_UV_WARN])
    else $error("undervoltage warning before arming");

  AST_TOO_LOW_NO_ALERT: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (iout_flags | input_flags | temp_flags | cml_flags) == 8'h00 |=> !alert_o)
    else $error("alert without latched flag");

  AST_MASK_BLOCKS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cml_flags != 8'h00 && alert_mask_cml_i == 8'hFF && iout_flags == 8'h00
      && input_flags == 8'h00 && temp_flags == 8'h00 |=> !alert_o)
    else $error("masked flag raised alert");

  AST_CML_SUMMARY: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ##1 status_byte_cml_o == |$past(cml_flags))
    else $error("summary bit mismatch");

  AST_READ_ANSWER: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_valid_i && !cmd_write_i && cmd_code_i == FSR_CODE_CML
      |=> rvalid_o && rdata_o == $past(cml_flags))
    else $error("read answer wrong");

  AST_BACK_CHANNEL: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    back_channel_error_evt_i |=> cml_flags[FSR_BIT_LINK])
    else $error("back-channel error not reported");

endmodule
`default_nettype wire

// ### hdl/fsr_pkg.sv
// fsr_pkg: command codes, field positions and reset values for the fault
// status register bank. assumes byte-wide registers addressed by command code.
package fsr_pkg;

  // command codes of the four status registers
  localparam logic [7:0] FSR_CODE_IOUT  = 8'h7B;
  localparam logic [7:0] FSR_CODE_INPUT = 8'h7C;
  localparam logic [7:0] FSR_CODE_TEMP  = 8'h7D;
  localparam logic [7:0] FSR_CODE_CML   = 8'h7E;

  // supported latched positions per register
  localparam logic [7:0] FSR_SUP_IOUT  = 8'hA0;
  localparam logic [7:0] FSR_SUP_INPUT = 8'hA0;
  localparam logic [7:0] FSR_SUP_TEMP  = 8'hC0;
  localparam logic [7:0] FSR_SUP_CML   = 8'hFA;

  // field positions
  localparam int FSR_BIT_OC_FAULT   = 7;
  localparam int FSR_BIT_OC_WARN    = 5;
  localparam int FSR_BIT_IN_OV_FLT  = 7;
  localparam int FSR_BIT_IN_UV_WARN = 5;
  localparam int FSR_BIT_IN_TOO_LOW = 3;
  localparam int FSR_BIT_OT_FAULT   = 7;
  localparam int FSR_BIT_OT_WARN    = 6;
  localparam int FSR_BIT_BAD_CMD    = 7;
  localparam int FSR_BIT_BAD_DATA   = 6;
  localparam int FSR_BIT_PEC        = 5;
  localparam int FSR_BIT_MEM        = 4;
  localparam int FSR_BIT_CORE       = 3;
  localparam int FSR_BIT_LINK       = 1;
  localparam int FSR_WORD_BIT_IOUT  = 14;
  localparam int FSR_WORD_BIT_INPUT = 13;

  // reset values
  localparam logic [7:0] FSR_RST_FLAGS   = 8'h00;
  localparam logic       FSR_RST_INPUT_TOO_LOW_LIVE_FLAG = 1'b1;
  localparam logic [7:0] FSR_RDATA_NONE  = 8'h00;

  // pin synchroniser depth
  localparam int FSR_SYNC_STAGES = 3;

endpackage

// ### hdl/fsr_pin_sync.sv
// fsr_pin_sync: three-stage synchroniser for an asynchronous level input.
// output changes only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module fsr_pin_sync
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // level
  input  wire logic async_i,
  output logic      level_o
);

  logic [FSR_SYNC_STAGES-1:0] stage;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage <= '0;
    end else begin
      stage <= {stage[FSR_SYNC_STAGES-2:0], async_i};
    end
  end

  // first stage only feeds the second; agreement filters a single-cycle glitch
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_o <= stage[2];
    end
  end

endmodule
`default_nettype wire

// ### hdl/fsr_sticky_byte.sv
// fsr_sticky_byte: one byte of latched flags, write-one-to-clear and clear-all.
// assumes set and clear strobes come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module fsr_sticky_byte
  import fsr_pkg::*;
#(
  parameter logic [7:0] SUPPORTED = 8'hFF
)(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // events and clears
  input  wire logic [7:0] set_i,
  input  wire logic [7:0] wr1c_i,
  input  wire logic       clr_all_i,
  // flags
  output logic [7:0]      flags_o
);

  logic [7:0] clr;

  assign clr = clr_all_i ? 8'hFF : wr1c_i;

  // set wins over clear; zero writes and unsupported positions change nothing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_o <= FSR_RST_FLAGS;
    end else begin
      flags_o <= ((flags_o & ~clr) | set_i) & SUPPORTED;
    end
  end

endmodule
`default_nettype wire

// ### test/fsr_host_model.sv
// fsr_host_model: management host issuing byte reads, byte writes and
// clear-faults on the bank's command port. assumes clk_i is shared with the bank.
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
  // clock
  input  wire logic       clk_i,
  // command port
  output logic            cmd_valid_o,
  output logic            cmd_write_o,
  output logic [7:0]      cmd_code_o,
  output logic [7:0]      cmd_wdata_o,
  output logic            clear_faults_o,
  // answer
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 8'h00;
    clear_faults_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o = code;
    cmd_wdata_o = data;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    // released lines show the inverse so stale values cannot pass
    cmd_write_o = ~wr;
    cmd_code_o = ~code;
    cmd_wdata_o = ~data;
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    issue(1'b1, code, data);
  endtask
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    data = 8'hxx;
    issue(1'b0, code, 8'h00);
    // bounded wait; a missing answer leaves unknown data for the compare
    for (int n = 0; n < 4; n++) begin
      if (rvalid_i === 1'b1) begin
        data = rdata_i;
        break;
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic clr();
    @(posedge clk_i);
    #1;
    clear_faults_o = 1'b1;
    @(posedge clk_i);
    #1;
    clear_faults_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// tb_top: self-checking bench for the fault status bank.
// assumes the host model owns the command port; events and levels come from here.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import fsr_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [12:0] evt = '0;
  logic        above_on = 1'b0;
  logic        below_off = 1'b1;
  logic        uvlo = 1'b0;
  logic [7:0]  mask = 8'h00;
  logic        cv, cw, cf, rv, alert, w_iout, w_in, b_cml, low;
  logic [7:0]  cc, cd, rdat;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  evt_code [13] = '{FSR_CODE_IOUT, FSR_CODE_IOUT, FSR_CODE_INPUT, FSR_CODE_INPUT, FSR_CODE_TEMP,
    FSR_CODE_TEMP, FSR_CODE_CML, FSR_CODE_CML, FSR_CODE_CML, FSR_CODE_CML, FSR_CODE_CML, FSR_CODE_CML, FSR_CODE_CML};
  logic [7:0]  evt_bit [13] = '{8'h80, 8'h20, 8'h80, 8'h20, 8'h80, 8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08,
    8'h02, 8'h02};

  always #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  fsr_host_model host (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_code_o(cc), .cmd_wdata_o(cd),
    .clear_faults_o(cf), .rvalid_i(rv), .rdata_i(rdat));
  fsr_fault_status uut (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_code_i(cc), .cmd_wdata_i(cd), .clear_faults_i(cf), .rvalid_o(rv), .rdata_o(rdat),
    .oc_fault_evt_i(evt[0]), .oc_warn_evt_i(evt[1]), .vin_ov_fault_evt_i(evt[2]), .vin_uv_warn_evt_i(evt[3]),
    .ot_fault_evt_i(evt[4]), .ot_warn_evt_i(evt[5]), .bad_command_evt_i(evt[6]), .bad_payload_evt_i(evt[7]),
    .pec_fail_evt_i(evt[8]), .memory_error_evt_i(evt[9]), .core_error_evt_i(evt[10]),
    .link_error_evt_i(evt[11]), .back_channel_error_evt_i(evt[12]), .power_input_rail_above_on_i(above_on),
    .power_input_rail_below_off_i(below_off), .aux_uvlo_i(uvlo), .alert_mask_iout_i(mask), .alert_mask_input_i(mask),
    .alert_mask_temp_i(mask), .alert_mask_cml_i(mask), .alert_o(alert), .status_word_iout_o(w_iout),
    .status_word_input_o(w_in), .status_byte_cml_o(b_cml), .input_too_low_live_flag_o(low));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    #1;
    evt[i] = 1'b1;
    @(posedge clk_i);
    #1;
    evt = '0;
  endtask
  // live summary output for a register; temperature has none, so alert stands in
  function automatic logic summary(input logic [7:0] code);
    return (code == FSR_CODE_IOUT) ? w_iout : (code == FSR_CODE_INPUT) ? w_in :
           (code == FSR_CODE_CML) ? b_cml : alert;
  endfunction
  task automatic rdchk(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(code, v);
    chk(exp, v);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ceiling well above the ~290 cycles the tests take
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] base;
    repeat (16) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    cyc(1);
    rdchk(FSR_CODE_IOUT, 8'h00);
    rdchk(FSR_CODE_INPUT, 8'h08);
    chk(8'h00, {7'h00, alert});
    chk(8'h01, {7'h00, low});
    rdchk(FSR_CODE_TEMP, 8'h00);
    rdchk(FSR_CODE_CML, 8'h00);
    pulse(3);
    cyc(3);
    rdchk(FSR_CODE_INPUT, 8'h08);
    chk(8'h00, {7'h00, alert});
    $display("test reset_state done");
    for (int i = 0; i < 13; i++) begin
      if (i == 3) continue;
      base = (evt_code[i] == FSR_CODE_INPUT) ? 8'h08 : 8'h00;
      pulse(i);
      cyc(3);
      rdchk(evt_code[i], evt_bit[i] | base);
      chk(8'h01, {7'h00, summary(evt_code[i])});
      chk(8'h01, {7'h00, alert});
      host.wr(evt_code[i], evt_bit[i]);
      cyc(2);
      rdchk(evt_code[i], base);
      chk(8'h00, {6'h00, summary(evt_code[i]), alert});
    end
    $display("test event_latch done");
    mask = 8'hC0;
    pulse(4);
    pulse(5);
    pulse(0);
    cyc(3);
    chk(8'h00, {7'h00, alert});
    chk(8'h01, {7'h00, w_iout});
    host.wr(FSR_CODE_TEMP, 8'h00);
    host.wr(FSR_CODE_TEMP, 8'h3F);
    host.wr(8'h7F, 8'hFF);
    rdchk(FSR_CODE_TEMP, 8'hC0);
    rdchk(FSR_CODE_CML, 8'h00);
    rdchk(8'h7F, 8'h00);
    host.wr(FSR_CODE_TEMP, 8'h40);
    rdchk(FSR_CODE_TEMP, 8'h80);
    rdchk(FSR_CODE_IOUT, 8'h80);
    host.clr();
    cyc(2);
    rdchk(FSR_CODE_TEMP, 8'h00);
    rdchk(FSR_CODE_IOUT, 8'h00);
    chk(8'h00, {7'h00, w_iout});
    mask = 8'hFF;
    pulse(8);
    cyc(3);
    chk(8'h00, {7'h00, alert});
    chk(8'h01, {7'h00, b_cml});
    host.wr(FSR_CODE_CML, 8'h20);
    mask = 8'h00;
    $display("test mask_and_clear done");
    above_on = 1'b1;
    below_off = 1'b0;
    cyc(8);
    rdchk(FSR_CODE_INPUT, 8'h00);
    chk(8'h00, {7'h00, low});
    pulse(3);
    cyc(3);
    rdchk(FSR_CODE_INPUT, 8'h20);
    chk(8'h03, {6'h00, w_in, alert});
    host.wr(FSR_CODE_INPUT, 8'h20);
    uvlo = 1'b1;
    cyc(8);
    rdchk(FSR_CODE_INPUT, 8'h08);
    chk(8'h00, {7'h00, alert});
    uvlo = 1'b0;
    cyc(8);
    rdchk(FSR_CODE_INPUT, 8'h00);
    $display("test live_input done");
    above_on = 1'b0;
    below_off = 1'b1;
    pulse(1);
    cyc(1);
    chk(8'h01, {7'h00, alert});
    resetn_i = 1'b0;
    cyc(3);
    resetn_i = 1'b1;
    cyc(1);
    chk(8'h01, {7'h00, low});
    chk(8'h00, {7'h00, alert});
    rdchk(FSR_CODE_IOUT, 8'h00);
    pulse(3);
    cyc(3);
    rdchk(FSR_CODE_INPUT, 8'h08);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
